// ---- verilog/eil_top.sv ----
// Purpose: external interrupt latch with Avalon-MM register port
// Assumes: irq pin active low, synchronous to nothing; bus clock 20 MHz
// Notes:   every access answers with one waitrequest cycle
//          pending = edge latch, or the low pin itself while in level mode
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "eil_params.svh"

module eil_top
  import eil_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire eil_avs_req_t avs_req,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // External pin and CPU side
  input  wire logic        ext_irq_n,
  input  wire logic        vector_fetch,
  input  wire logic        cpu_global_mask,
  input  wire logic        break_state,
  input  wire logic        break_clear_enable,
  // Outputs
  output logic             cpu_irq_req,
  output logic             pin_level,
  output logic             branch_if_pin_high,
  output logic             branch_if_pin_low,
  output logic             irq
);

  // ===========================================================
  // Pin synchroniser and edge detect
  logic [1:0] sync;
  logic       prev;
  logic       fall;
  logic [1:0] next_sync;
  logic       next_prev;

  // First stage feeds the second stage and, as next_sync[1], the next_pend look-ahead
  always_comb begin
    next_sync = {sync[0], ext_irq_n};
    next_prev = sync[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Load the pin level: a pin held low through reset is no edge
      sync <= {ext_irq_n, ext_irq_n};
      prev <= ext_irq_n;
    end else begin
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign fall = prev & ~sync[1];

  // ===========================================================
  // Bus decode
  logic       acc;
  logic       wr_ctrl;
  logic       wr_st;
  logic       wr_msk;
  eil_state_t state;
  eil_state_t next_state;

  assign acc     = (avs_req.read | avs_req.write) && (state == EIL_IDLE);
  assign wr_ctrl = acc && avs_req.write && avs_req.address == `EIL_OFS_CTRL;
  assign wr_st   = acc && avs_req.write && avs_req.address == `EIL_OFS_IRQST;
  assign wr_msk  = acc && avs_req.write && avs_req.address == `EIL_OFS_IRQMSK;

  // ===========================================================
  // Control bits and request latch
  logic mode;
  logic lmask;
  logic latch;
  logic next_mode;
  logic next_lmask;
  logic next_latch;
  logic ack;
  logic sw_ack;
  logic pend;
  logic next_pend;

  // Break without clear enable protects the latch from software
  assign sw_ack = wr_ctrl && avs_req.writedata[`EIL_BIT_ACK]
                  && !(break_state && !break_clear_enable);
  assign ack    = vector_fetch | sw_ack;

  always_comb begin
    next_mode  = mode;
    next_lmask = lmask;
    if (wr_ctrl) begin
      next_mode  = avs_req.writedata[`EIL_BIT_MODE];
      next_lmask = avs_req.writedata[`EIL_BIT_MASK];
    end
    next_latch = latch;
    if (ack)
      next_latch = 1'b0;
    // Set after clear: a new edge is never lost
    if (fall)
      next_latch = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode  <= 1'b0;
      lmask <= 1'b0;
      latch <= 1'b0;
    end else begin
      mode  <= next_mode;
      lmask <= next_lmask;
      latch <= next_latch;
    end
  end

  // Level term keeps the request while the pin is low, so an ack may come first
  assign pend      = latch | (mode & ~sync[1]);
  assign next_pend = next_latch | (next_mode & ~next_sync[1]);

  // Priority logic request; vector load is the CPU's job on this
  assign cpu_irq_req        = pend & ~lmask & ~cpu_global_mask;
  assign pin_level          = sync[1];
  assign branch_if_pin_high = sync[1];
  assign branch_if_pin_low  = ~sync[1];

  // ===========================================================
  // Sticky events, mask, interrupt output
  logic [1:0] ev;
  logic [1:0] ev_msk;
  logic [1:0] next_ev;
  logic [1:0] next_ev_msk;
  logic [1:0] ev_set;

  assign ev_set = {fall, next_pend & ~pend};

  // Set wins over write-one-to-clear
  always_comb begin
    next_ev     = ev;
    next_ev_msk = ev_msk;
    if (wr_st)
      next_ev = ev & ~avs_req.writedata[1:0];
    next_ev = next_ev | ev_set;
    if (wr_msk)
      next_ev_msk = avs_req.writedata[1:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev     <= `EIL_RST_IRQ;
      ev_msk <= `EIL_RST_IRQ;
    end else begin
      ev     <= next_ev;
      ev_msk <= next_ev_msk;
    end
  end

  assign irq = |(ev & ev_msk);

  // ===========================================================
  // Avalon answer: one wait cycle, then data at release edge
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb begin
    next_state = state;
    next_rdata = rdata;
    case (state)
      EIL_IDLE: begin
        if (avs_req.read | avs_req.write) begin
          next_state = EIL_DONE;
          next_rdata = 32'h0;
          if (avs_req.read) begin
            case (avs_req.address)
              `EIL_OFS_CTRL:   next_rdata = {27'h0, sync[1], pend, 1'b0, lmask, mode};
              `EIL_OFS_IRQST:  next_rdata = {30'h0, ev};
              `EIL_OFS_IRQMSK: next_rdata = {30'h0, ev_msk};
              default:         next_rdata = 32'h0;
            endcase
          end
        end
      end
      EIL_DONE: next_state = EIL_IDLE;
      default:  next_state = EIL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= EIL_IDLE;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  assign avs_readdata    = rdata;
  assign avs_waitrequest = (state == EIL_IDLE);

  // ===========================================================
  // Assertions
  property p_edge_sets;
    @(posedge clk) disable iff (!rst_n) fall |=> latch;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch");

  property p_ack_clears;
    @(posedge clk) disable iff (!rst_n) (ack && !fall && !next_mode) |=> !pend;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear latch");

  property p_level_holds;
    @(posedge clk) disable iff (!rst_n) (mode && !sync[1] && !sync[0] && !wr_ctrl) |=> pend;
  endproperty
  a_level_holds: assert property (p_level_holds) else $error("level mode dropped request");

  property p_mask;
    @(posedge clk) disable iff (!rst_n) (lmask || cpu_global_mask) |-> !cpu_irq_req;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request presented");

  property p_present;
    @(posedge clk) disable iff (!rst_n) (pend && !lmask && !cpu_global_mask) |-> cpu_irq_req;
  endproperty
  a_present: assert property (p_present) else $error("request not presented");

  property p_break;
    @(posedge clk) disable iff (!rst_n)
      (latch && !vector_fetch && break_state && !break_clear_enable) |=> latch;
  endproperty
  a_break: assert property (p_break) else $error("break ack cleared latch");

  property p_sync;
    @(posedge clk) disable iff (!rst_n) $fell(ext_irq_n) |-> ##2 !sync[1] || $rose(ext_irq_n);
  endproperty
  a_sync: assert property (p_sync) else $error("sync lag wrong");

  property p_reset;
    @(posedge clk) !rst_n |=> (!pend && !mode);
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state");

  property p_ack_read;
    @(posedge clk) disable iff (!rst_n) (state == EIL_DONE) |-> !avs_readdata[`EIL_BIT_ACK];
  endproperty
  a_ack_read: assert property (p_ack_read) else $error("ack bit read as one");

  // Reset with the pin low must not leave a false edge behind
  property p_reset_quiet;
    @(posedge clk) (!rst_n ##1 rst_n) |=> !latch;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("edge latched after reset");

  // Acknowledge sources and level release
  property p_vector_ack;
    @(posedge clk) disable iff (!rst_n) (vector_fetch && !fall) |=> !latch;
  endproperty
  a_vector_ack: assert property (p_vector_ack) else $error("vector fetch kept latch");

  property p_sw_ack;
    @(posedge clk) disable iff (!rst_n) (sw_ack && !fall) |=> !latch;
  endproperty
  a_sw_ack: assert property (p_sw_ack) else $error("software ack kept latch");

  property p_edge_only;
    @(posedge clk) disable iff (!rst_n) (!mode && !next_mode && !pend && !fall) |=> !pend;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("edge mode took a level");

  property p_level_release;
    @(posedge clk) disable iff (!rst_n) (ack && !fall && next_mode) |=> (pend == !sync[1]);
  endproperty
  a_level_release: assert property (p_level_release) else $error("level release wrong");

  property p_rearm;
    @(posedge clk) disable iff (!rst_n) (sw_ack ##1 fall) |=> latch;
  endproperty
  a_rearm: assert property (p_rearm) else $error("edge after ack lost");

  // Register side
  property p_pending_flag;
    @(posedge clk) disable iff (!rst_n) (acc && avs_req.read && avs_req.address == `EIL_OFS_CTRL)
      |=> (avs_readdata[`EIL_BIT_PEND] == $past(pend));
  endproperty
  a_pending_flag: assert property (p_pending_flag) else $error("pending flag read wrong");

  property p_pin_branch;
    @(posedge clk) disable iff (!rst_n) (ext_irq_n && $past(ext_irq_n))
      |=> (branch_if_pin_high && !branch_if_pin_low);
  endproperty
  a_pin_branch: assert property (p_pin_branch) else $error("pin level not shown");

  property p_mode_rw;
    @(posedge clk) disable iff (!rst_n) wr_ctrl |=> (mode == $past(avs_req.writedata[`EIL_BIT_MODE]));
  endproperty
  a_mode_rw: assert property (p_mode_rw) else $error("mode bit not written");

  property p_mask_rw;
    @(posedge clk) disable iff (!rst_n) wr_ctrl |=> (lmask == $past(avs_req.writedata[`EIL_BIT_MASK]));
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("mask bit not written");

  // Main scenarios the bench should reach
  c_edge:  cover property (@(posedge clk) disable iff (!rst_n) fall ##[1:20] ack);
  c_level: cover property (@(posedge clk) disable iff (!rst_n) mode && ack && !sync[1]);
  c_irq:   cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_rel:   cover property (@(posedge clk) disable iff (!rst_n) (mode && ack && !sync[1]) ##[1:40] (mode && !pend));
  c_brk:   cover property (@(posedge clk) disable iff (!rst_n)
                           break_state && !break_clear_enable && wr_ctrl && avs_req.writedata[`EIL_BIT_ACK]);

endmodule

// ---- verilog/eil_params.svh ----
// Purpose: constants for the external interrupt latch block
// Assumes: 20 MHz bus clock, Avalon-MM word registers
// Notes:   offsets are byte addresses of aligned 32-bit words
//
// Functional notes
// - Low pin per trigger mode sets latch
// - Vector fetch acknowledge clears latch
// - Software acknowledge write clears latch
// - Reset clears latch and trigger mode
// - Edge mode: acknowledge clears immediately
// - Level mode: needs acknowledge and pin high
// - Level mode: pending while pin low
// - Local mask blocks request, keeps latch
// - CPU global mask also blocks request
// - Falling edge after acknowledge latches again
// - Pending flag ignores local mask
// - Pin level readable for branch tests
// - Trigger mode bit read/write, 1 level
// - Acknowledge bit write-only, reads zero
// - Local mask read/write, reset clear
// - Break without clear enable blocks acknowledge (software only here; vector fetch still clears latch)
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

// ===========================================================
// Register offsets
`define EIL_OFS_CTRL   4'h0
`define EIL_OFS_IRQST  4'h4
`define EIL_OFS_IRQMSK 4'h8

// ===========================================================
// Control register fields
`define EIL_BIT_MODE    0
`define EIL_BIT_MASK    1
`define EIL_BIT_ACK     2
`define EIL_BIT_PEND    3
`define EIL_BIT_PIN     4

// ===========================================================
// Status / mask fields and reset values
`define EIL_BIT_EV_LATCH 0
`define EIL_BIT_EV_EDGE  1
`define EIL_RST_CTRL     2'h0
`define EIL_RST_IRQ      2'h0
`define EIL_RST_SYNC     2'h3

`endif

// ---- verilog/eil_pkg.sv ----
// Purpose: shared types of the external interrupt latch
// Assumes: constants live in eil_params.svh
// Notes:   types only
package eil_pkg;
  // Avalon-MM request from the master
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } eil_avs_req_t;

  // Answer FSM, one-hot
  typedef enum logic [1:0] {
    EIL_IDLE = 2'b01,
    EIL_DONE = 2'b10
  } eil_state_t;
endpackage

// ---- test/eil_pin_model.sv ----
// Purpose: external device driving the interrupt pin
// Assumes: pin has a pullup, released pin reads high
// Notes:   bench raises hold to pull the pin low
`timescale 1ns/1ps
module eil_pin_model (
  // Bench side
  input  wire logic hold,
  // Pin, active low
  output logic      pin_n
);
  // Released pin goes to the pullup level, never a stale value
  assign pin_n = hold ? 1'b0 : 1'b1;
endmodule

// ---- test/external_interrupt_latch_test.sv ----
// Purpose: self-checking bench of the external interrupt latch
// Assumes: Avalon-MM master, pin model with pullup
// Notes:   expectations come from the bench model m_*
`timescale 1ns/1ps
`include "eil_params.svh"
module external_interrupt_latch_test
  import eil_pkg::*;
;
  // ====
  // Stimulus, model and counters
  logic         clk = 0, rst_n = 0, hold = 0, vf = 0, gm = 0, brk = 0, bce = 0;
  eil_avs_req_t req = '0;
  logic [31:0]  rd, q;
  logic         wq, cirq, plev, bh, bl, irq, pin_n, m_mode, m_mask, m_lat;
  logic [15:0]  rnd = 16'h7E29;
  int           n_errors = 0, samples_checked = 0, cyc = 0;

  // Clock, 50 ns period
  always #25 clk = ~clk;

  eil_pin_model eil_pin_model_inst (.hold(hold), .pin_n(pin_n));
  eil_top eil_top_inst (.clk(clk), .rst_n(rst_n), .avs_req(req), .avs_readdata(rd),
    .avs_waitrequest(wq), .ext_irq_n(pin_n), .vector_fetch(vf), .cpu_global_mask(gm),
    .break_state(brk), .break_clear_enable(bce), .cpu_irq_req(cirq), .pin_level(plev),
    .branch_if_pin_high(bh), .branch_if_pin_low(bl), .irq(irq));

  // ====
  // Helpers
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Hold the request until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    rnd = lfsr(rnd);
    req <= '{a, ~w, w, {rnd, d}};  // Upper data bits are unused noise
    // Sampled at the rising edge; ends when waitrequest is low, else the hang guard ends it
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rd;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  // Pin change, then a random settle beyond the sync delay
  task pin(input logic v);
    @(posedge clk);
    hold <= v;
    rnd = lfsr(rnd);
    wt(5 + rnd[2:0]);
  endtask

  task vfp;
    @(posedge clk);
    vf <= 1'b1;
    @(posedge clk);
    vf <= 1'b0;
    wt(2);
  endtask

  task ack;
    bus(1'b1, `EIL_OFS_CTRL, {13'h0, 1'b1, m_mask, m_mode});
    wt(2);
  endtask

  // Compare design with the model
  task cmp;
    bus(1'b0, `EIL_OFS_CTRL, 16'h0);
    @(negedge clk);
    chk("ctrl", q, {27'h0, ~hold, m_lat, 1'b0, m_mask, m_mode});
    chk("cpu_irq_req", cirq, m_lat & ~m_mask & ~gm);
    chk("pin", {bh, bl, plev}, {~hold, hold, ~hold});
  endtask

  task print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ====
  // Main sequence
  initial begin
    m_mode = 0; m_mask = 0; m_lat = 0;
    wt(2);
    rst_n <= 1'b1;
    cmp();
    bus(1'b0, 4'hC, 16'h0);
    chk("unmapped", q, 32'h0);
    pin(1'b1); m_lat = 1; cmp();
    vfp(); m_lat = 0; cmp();
    pin(1'b0); pin(1'b1); m_lat = 1;
    ack(); m_lat = 0; cmp();
    pin(1'b0); pin(1'b1); m_lat = 1; cmp();
    bus(1'b1, `EIL_OFS_CTRL, 16'h2); m_mask = 1; cmp();
    bus(1'b1, `EIL_OFS_CTRL, 16'h0); m_mask = 0;
    @(posedge clk); gm <= 1'b1; cmp();
    @(posedge clk); gm <= 1'b0;
    // Sticky events, mask, level output, write-one-to-clear
    bus(1'b0, `EIL_OFS_IRQST, 16'h0); chk("status", q, 32'h3);
    @(negedge clk); chk("irq", irq, 32'h0);
    bus(1'b1, `EIL_OFS_IRQMSK, 16'h3); @(negedge clk); chk("irq", irq, 32'h1);
    bus(1'b1, `EIL_OFS_IRQST, 16'h3); @(negedge clk); chk("irq", irq, 32'h0);
    bus(1'b0, `EIL_OFS_IRQST, 16'h0); chk("status", q, 32'h0);
    // Break state guards the latch unless clearing is enabled
    @(posedge clk); brk <= 1'b1;
    ack(); cmp();
    @(posedge clk); bce <= 1'b1;
    ack(); m_lat = 0; cmp();
    @(posedge clk); brk <= 1'b0; bce <= 1'b0;
    // Level mode, both orders of acknowledge and pin release
    bus(1'b1, `EIL_OFS_CTRL, 16'h1); m_mode = 1; m_lat = 1; cmp();
    bus(1'b1, `EIL_OFS_CTRL, 16'h3); m_mask = 1; ack(); cmp();
    pin(1'b0); m_lat = 0; cmp();
    bus(1'b1, `EIL_OFS_CTRL, 16'h1); m_mask = 0;
    pin(1'b1); m_lat = 1; pin(1'b0); cmp();
    vfp(); m_lat = 0; cmp();
    // Reset in mid-run with the pin held low
    pin(1'b1);
    @(posedge clk); rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1; m_mode = 0; m_lat = 0; cmp();
    pin(1'b0);
    print_verdict();
  end
endmodule
